/* File: flag_shift_pkg.sv */
// constants for the flag, shift and bit-skip instruction executor
package flag_shift_pkg;

    // apb register byte addresses
    localparam logic [7:0] ADDR_INSTR    = 8'h00;
    localparam logic [7:0] ADDR_STATE    = 8'h04;
    localparam logic [7:0] ADDR_PC       = 8'h08;
    localparam logic [7:0] ADDR_RAM_ADDR = 8'h0c;
    localparam logic [7:0] ADDR_RAM_DATA = 8'h10;

    // field positions in the state register and in the parameter nibble
    localparam int STATE_ACC_LSB   = 0;
    localparam int STATE_CARRY_BIT = 4;
    localparam int STATE_ZERO_BIT  = 5;
    localparam int STATE_SKIP_BIT  = 6;
    localparam int STATE_PMF_LSB   = 8;
    localparam int PMF_WDT_SEL_BIT = 3;

    // opcode prefixes, matched against the top bits of the 16-bit word
    localparam logic [7:0]  OP_FORCE_CARRY_HIGH  = 8'h50;
    localparam logic [11:0] OP_WRITE_PARAM_FLAGS = 12'h160;
    localparam logic [8:0]  OP_SHIFT_LEFT        = 9'h098;
    localparam logic [8:0]  OP_SHIFT_RIGHT       = 9'h09a;
    localparam logic [8:0]  OP_SKIP_BIT_ZERO     = 9'h110;
    localparam logic [8:0]  OP_SKIP_BIT_ONE      = 9'h111;

    // values after reset
    localparam logic [3:0]  ACC_RST  = 4'h0;
    localparam logic [3:0]  PMF_RST  = 4'h0;
    localparam logic [10:0] PC_RST   = 11'h000;
    localparam logic [6:0]  RADR_RST = 7'h00;

    // program counter steps and timing
    localparam logic [10:0] PC_STEP      = 11'h001;
    localparam logic [10:0] PC_SKIP_STEP = 11'h002;
    localparam int MACHINE_CYCLES   = 1;
    localparam int WDT_SLOW_DIVISOR = 16384;

endpackage : flag_shift_pkg

/* File: flag_shift_skip_instr_exec.sv */
// flag, shift and bit-skip instruction executor behind an apb slave
`timescale 1ns/1ps
module flag_shift_skip_instr_exec
    import flag_shift_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        rst,
    input  wire logic        ce,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic      [10:0] pc,
    output logic      [3:0]  accumulator,
    output logic             carryFlag,
    output logic             zeroFlag,
    output logic      [3:0]  parameterFlagNibble,
    output logic             wdtSlowClkSel,
    output logic             execDone
);

    // 128 x 4 data ram
    logic [3:0] dataRam [0:127];

    logic [6:0]  ramAddr;
    logic        skipTaken;
    logic        rdCaptured;

    logic [10:0] next_pc;
    logic [3:0]  next_accumulator;
    logic        next_carryFlag;
    logic        next_zeroFlag;
    logic [3:0]  next_parameterFlagNibble;
    logic [6:0]  next_ramAddr;
    logic        next_skipTaken;
    logic        next_execDone;
    logic [31:0] next_prdata;
    logic        next_rdCaptured;

    logic        memWe;
    logic [6:0]  memWa;
    logic [3:0]  memWd;

    logic        apbWr;
    logic        rdLoad;
    logic        exec;
    logic [15:0] instr;
    logic [6:0]  operandAddr;
    logic [3:0]  operand;
    logic        isForceCarry;
    logic        isWriteParam;
    logic        isShiftLeft;
    logic        isShiftRight;
    logic        isSkipZero;
    logic        isSkipOne;

    function automatic logic isZero(input logic [3:0] v);
        isZero = (v == 4'h0);
    endfunction : isZero

    function automatic logic isMapped(input logic [7:0] a);
        isMapped = (a == ADDR_INSTR) || (a == ADDR_STATE) || (a == ADDR_PC)
                || (a == ADDR_RAM_ADDR) || (a == ADDR_RAM_DATA);
    endfunction : isMapped

    // zero-wait slave; while ce is low every access stalls
    // a read whose setup fell in a frozen cycle gets one wait state to load prdata
    assign pready     = ce && !(psel && penable && !pwrite && !rdCaptured);
    assign pslverr    = psel && penable && pready && !isMapped(paddr);
    assign apbWr      = psel && penable && pwrite && ce && isMapped(paddr);
    assign rdLoad     = psel && !pwrite && ce && !rdCaptured;

    // an instruction word written to the instruction register runs in one machine cycle
    assign exec        = apbWr && (paddr == ADDR_INSTR);
    assign instr       = pwdata[15:0];
    assign operandAddr = instr[6:0];
    assign operand     = dataRam[operandAddr];

    assign isForceCarry = (instr[15:8] == OP_FORCE_CARRY_HIGH);
    assign isWriteParam = (instr[15:4] == OP_WRITE_PARAM_FLAGS);
    assign isShiftLeft  = (instr[15:7] == OP_SHIFT_LEFT);
    assign isShiftRight = (instr[15:7] == OP_SHIFT_RIGHT);
    assign isSkipZero   = (instr[15:7] == OP_SKIP_BIT_ZERO);
    assign isSkipOne    = (instr[15:7] == OP_SKIP_BIT_ONE);

    assign wdtSlowClkSel = parameterFlagNibble[PMF_WDT_SEL_BIT];

    always_comb begin
        next_pc                  = pc;
        next_accumulator         = accumulator;
        next_carryFlag           = carryFlag;
        next_zeroFlag            = zeroFlag;
        next_parameterFlagNibble = parameterFlagNibble;
        next_ramAddr             = ramAddr;
        next_skipTaken           = skipTaken;
        next_execDone            = 1'b0;
        memWe                    = 1'b0;
        memWa                    = ramAddr;
        memWd                    = pwdata[3:0];
        if (exec) begin
            // unknown opcodes only advance the program counter and clear the skip flag
            next_execDone  = 1'b1;
            next_skipTaken = 1'b0;
            next_pc        = pc + PC_STEP;
            if (isForceCarry) begin
                next_carryFlag = 1'b1;
            end else if (isWriteParam) begin
                // reserved bits are stored and read back but drive nothing
                next_parameterFlagNibble = instr[3:0];
            end else if (isShiftLeft) begin
                memWd            = {operand[2:0], 1'b0};
                next_carryFlag   = operand[3];
                next_accumulator = memWd;
                next_zeroFlag    = isZero(memWd);
                memWe            = 1'b1;
                memWa            = operandAddr;
            end else if (isShiftRight) begin
                memWd            = {1'b0, operand[3:1]};
                next_carryFlag   = operand[0];
                next_accumulator = memWd;
                next_zeroFlag    = isZero(memWd);
                memWe            = 1'b1;
                memWa            = operandAddr;
            end else if ((isSkipZero && operand[0]) || (isSkipOne && operand[1])) begin
                next_skipTaken = 1'b1;
                next_pc        = pc + PC_SKIP_STEP;
            end
        end else if (apbWr) begin
            case (paddr)
                ADDR_STATE: begin
                    next_accumulator = pwdata[STATE_ACC_LSB +: 4];
                    next_carryFlag   = pwdata[STATE_CARRY_BIT];
                    next_zeroFlag    = pwdata[STATE_ZERO_BIT];
                end
                ADDR_PC: begin
                    next_pc = pwdata[10:0];
                end
                ADDR_RAM_ADDR: begin
                    next_ramAddr = pwdata[6:0];
                end
                ADDR_RAM_DATA: begin
                    memWe = 1'b1;
                end
                default: begin
                end
            endcase
        end
    end

    // read data is captured in the setup phase so prdata comes from a flop
    always_comb begin
        next_prdata     = prdata;
        next_rdCaptured = rdLoad || (rdCaptured && psel && !(penable && pready));
        if (rdLoad) begin
            next_prdata = 32'h0000_0000;
            case (paddr)
                ADDR_STATE: begin
                    next_prdata[STATE_ACC_LSB +: 4] = accumulator;
                    next_prdata[STATE_CARRY_BIT]    = carryFlag;
                    next_prdata[STATE_ZERO_BIT]     = zeroFlag;
                    next_prdata[STATE_SKIP_BIT]     = skipTaken;
                    next_prdata[STATE_PMF_LSB +: 4] = parameterFlagNibble;
                end
                ADDR_PC: begin
                    next_prdata[10:0] = pc;
                end
                ADDR_RAM_ADDR: begin
                    next_prdata[6:0] = ramAddr;
                end
                ADDR_RAM_DATA: begin
                    next_prdata[3:0] = dataRam[ramAddr];
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            pc                  <= PC_RST;
            accumulator         <= ACC_RST;
            carryFlag           <= 1'b0;
            zeroFlag            <= 1'b0;
            parameterFlagNibble <= PMF_RST;
            ramAddr             <= RADR_RST;
            skipTaken           <= 1'b0;
            execDone            <= 1'b0;
            prdata              <= 32'h0000_0000;
            rdCaptured          <= 1'b0;
        end else if (ce) begin
            pc                  <= next_pc;
            accumulator         <= next_accumulator;
            carryFlag           <= next_carryFlag;
            zeroFlag            <= next_zeroFlag;
            parameterFlagNibble <= next_parameterFlagNibble;
            ramAddr             <= next_ramAddr;
            skipTaken           <= next_skipTaken;
            execDone            <= next_execDone;
            prdata              <= next_prdata;
            rdCaptured          <= next_rdCaptured;
        end
    end

    // ram contents are not reset; software initialises what it uses
    // no ce term here: memWe is only raised while ce is high
    always_ff @(posedge sys_clk) begin
        if (memWe) begin
            dataRam[memWa] <= memWd;
        end
    end

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    AST_FORCE_CARRY: assert property (
        exec && isForceCarry |=> carryFlag && $stable(accumulator) && $stable(zeroFlag))
        else $error("force carry did not set carry alone");

    AST_WDT_SELECT: assert property (
        exec && isWriteParam |=> wdtSlowClkSel == $past(instr[PMF_WDT_SEL_BIT]))
        else $error("watchdog select does not follow immediate bit 3");

    AST_PMF_RESERVED: assert property (
        exec && isWriteParam && (instr[PMF_WDT_SEL_BIT] == wdtSlowClkSel)
        |=> $stable(wdtSlowClkSel) && $stable(carryFlag) && $stable(accumulator))
        else $error("reserved parameter bits had an effect");

    AST_SHIFT_LEFT: assert property (
        exec && isShiftLeft |=> accumulator == {$past(operand[2:0]), 1'b0}
            && carryFlag == $past(operand[3]))
        else $error("shift left result or carry wrong");

    AST_SHIFT_RIGHT: assert property (
        exec && isShiftRight |=> accumulator == {1'b0, $past(operand[3:1])}
            && carryFlag == $past(operand[0]))
        else $error("shift right result or carry wrong");

    AST_SHIFT_ADDR: assert property (
        exec && (isShiftLeft || isShiftRight) |-> memWe && memWa == pwdata[6:0]
            ##1 dataRam[$past(pwdata[6:0])] == accumulator)
        else $error("shift wrote the wrong ram word");

    AST_SKIP_ZERO: assert property (
        exec && isSkipZero && operand[0] |=> pc == $past(pc) + PC_SKIP_STEP && skipTaken)
        else $error("bit zero skip not taken");

    AST_SKIP_ONE: assert property (
        exec && isSkipOne && operand[1] |=> pc == $past(pc) + PC_SKIP_STEP && skipTaken)
        else $error("bit one skip not taken");

    AST_PC_STEP: assert property (
        exec && !((isSkipZero && operand[0]) || (isSkipOne && operand[1]))
        |=> pc == $past(pc) + PC_STEP && !skipTaken)
        else $error("program counter did not step by one");

    AST_ZERO_FLAG: assert property (
        exec && (isShiftLeft || isShiftRight) |=> zeroFlag == (accumulator == 4'h0))
        else $error("zero flag does not match result");

    AST_DONE_PULSE: assert property (
        exec |=> execDone ##1 (!execDone || $past(exec)))
        else $error("execution done pulse malformed");

    AST_CE_FREEZE: assert property (
        !ce |=> $stable(pc) && $stable(accumulator) && $stable(carryFlag) && $stable(zeroFlag)
            && $stable(parameterFlagNibble) && $stable(ramAddr) && $stable(prdata))
        else $error("state changed while clock enable was low");

    AST_SKIP_FLAGS: assert property (
        exec && (isSkipZero || isSkipOne) |=> $stable(accumulator) && $stable(carryFlag)
            && $stable(zeroFlag))
        else $error("bit test changed a flag or the accumulator");

    AST_RAM_WRITE: assert property (
        apbWr && (paddr == ADDR_RAM_DATA) |=> dataRam[$past(ramAddr)] == $past(pwdata[3:0]))
        else $error("ram data write did not land");

    AST_OTHER_OPCODE: assert property (
        exec && !(isForceCarry || isWriteParam || isShiftLeft || isShiftRight)
        |=> $stable(accumulator) && $stable(carryFlag) && $stable(zeroFlag)
            && $stable(parameterFlagNibble))
        else $error("non-writing opcode changed state");

    AST_UNMAPPED: assert property (
        psel && penable && pready && !isMapped(paddr) |=> $stable(pc) && $stable(ramAddr)
            && $stable(accumulator) && $stable(carryFlag))
        else $error("unmapped access changed state");

    AST_DONE_ONLY_EXEC: assert property (
        !exec |=> !execDone)
        else $error("execution done without an instruction");

    COV_SHIFT_LEFT_ZERO: cover property (exec && isShiftLeft ##1 zeroFlag && carryFlag);
    COV_SKIP_TAKEN: cover property (exec && isSkipOne ##1 skipTaken);
    COV_SKIP_NOT_TAKEN: cover property (exec && isSkipZero && !operand[0]);
    COV_WDT_SLOW: cover property (exec && isWriteParam ##1 wdtSlowClkSel);
    COV_READ_STALL: cover property (psel && penable && !pwrite && ce && !rdCaptured);

endmodule : flag_shift_skip_instr_exec

/* File: testbench.sv */
// self-checking bench for the flag, shift and bit-skip executor
`timescale 1ns/1ps
module testbench
    import flag_shift_pkg::*;
;
    logic        sys_clk;
    logic        rst;
    logic        ce;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [10:0] pc;
    logic [3:0]  accumulator;
    logic        carryFlag;
    logic        zeroFlag;
    logic [3:0]  parameterFlagNibble;
    logic        wdtSlowClkSel;
    logic        execDone;
    logic [15:0] wdtDivisor;
    logic [31:0] rdData;
    logic        rdErr;
    int          errTotal;
    int          nChecks;

    flag_shift_skip_instr_exec dut_u (.sys_clk(sys_clk), .rst(rst), .ce(ce), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .pc(pc), .accumulator(accumulator),
        .carryFlag(carryFlag), .zeroFlag(zeroFlag), .parameterFlagNibble(parameterFlagNibble),
        .wdtSlowClkSel(wdtSlowClkSel), .execDone(execDone));
    wdt_clock_model wdt_u (.wdtSlowClkSel(wdtSlowClkSel), .wdtDivisor(wdtDivisor));

    task automatic results();
        if (errTotal == 0 && nChecks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : results

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        nChecks++;
        if (seen !== exp) begin
            errTotal++;
            $display("FAIL t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask : check

    task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] data);
        @(posedge sys_clk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= addr;
        pwdata  <= data;
        @(posedge sys_clk);
        penable <= 1'b1;
        do @(posedge sys_clk); while (pready !== 1'b1);
        rdData = prdata;
        rdErr = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // operand address comes from op[6:0]; the RAM pointer is aimed there to read it back
    task automatic run_op(input logic [15:0] op, input logic [3:0] ramVal,
                          input logic [5:0] preState, input logic [5:0] expState,
                          input logic [3:0] expRam, input logic [10:0] pcStep);
        logic [10:0] pc0;
        apb(1'b1, ADDR_RAM_ADDR, {25'h0, op[6:0]});
        apb(1'b1, ADDR_RAM_DATA, {28'h0, ramVal});
        apb(1'b1, ADDR_STATE, {26'h0, preState});
        apb(1'b0, ADDR_PC, 32'h0);
        pc0 = rdData[10:0];
        apb(1'b1, ADDR_INSTR, {16'h0, op});
        #1 check({31'h0, execDone}, 32'h1);
        check({26'h0, zeroFlag, carryFlag, accumulator}, {26'h0, expState});
        apb(1'b0, ADDR_STATE, 32'h0);
        check({25'h0, rdData[6:0]}, {25'h0, pcStep == PC_SKIP_STEP, expState});
        apb(1'b0, ADDR_PC, 32'h0);
        check({21'h0, rdData[10:0]}, {21'h0, 11'(pc0 + pcStep)});
        apb(1'b0, ADDR_RAM_DATA, 32'h0);
        check({28'h0, rdData[3:0]}, {28'h0, expRam});
    endtask : run_op

    task automatic t_reset();
        apb(1'b0, ADDR_STATE, 32'h0);
        check(rdData, 32'h0);
        apb(1'b0, 8'h20, 32'h0);
        check({31'h0, rdErr}, 32'h1);
        check(rdData, 32'h0);
    endtask : t_reset

    task automatic t_force_carry();
        run_op(16'h50a5, 4'h3, 6'h26, 6'h36, 4'h3, PC_STEP);
        run_op(16'h50ff, 4'h9, 6'h00, 6'h10, 4'h9, PC_STEP);
    endtask : t_force_carry

    task automatic t_param();
        apb(1'b1, ADDR_INSTR, 32'h0000_1608);
        #1 check({31'h0, wdtSlowClkSel}, 32'h1);
        check({16'h0, wdtDivisor}, 32'h0000_4000);
        apb(1'b1, ADDR_INSTR, 32'h0000_160f);
        #1 check({28'h0, parameterFlagNibble}, 32'hf);
        check({31'h0, wdtSlowClkSel}, 32'h1);
        apb(1'b1, ADDR_INSTR, 32'h0000_1607);
        #1 check({31'h0, wdtSlowClkSel}, 32'h0);
        apb(1'b0, ADDR_STATE, 32'h0);
        check({28'h0, rdData[11:8]}, 32'h7);
    endtask : t_param

    task automatic t_shift_left();
        run_op(16'h4c45, 4'h9, 6'h00, 6'h12, 4'h2, PC_STEP);
        run_op(16'h4c7f, 4'h8, 6'h00, 6'h30, 4'h0, PC_STEP);
        run_op(16'h4c00, 4'h7, 6'h10, 6'h0e, 4'he, PC_STEP);
    endtask : t_shift_left

    task automatic t_shift_right();
        run_op(16'h4d45, 4'h1, 6'h00, 6'h30, 4'h0, PC_STEP);
        run_op(16'h4d7f, 4'he, 6'h10, 6'h07, 4'h7, PC_STEP);
    endtask : t_shift_right

    task automatic t_skip();
        run_op(16'h8845, 4'h1, 6'h15, 6'h15, 4'h1, PC_SKIP_STEP);
        run_op(16'h8845, 4'h2, 6'h15, 6'h15, 4'h2, PC_STEP);
        run_op(16'h88ff, 4'h2, 6'h20, 6'h20, 4'h2, PC_SKIP_STEP);
        run_op(16'h88ff, 4'hd, 6'h20, 6'h20, 4'hd, PC_STEP);
    endtask : t_skip

    task automatic t_ce_low();
        logic [10:0] pcHeld;
        pcHeld = pc;
        @(posedge sys_clk);
        ce <= 1'b0;
        // a write that starts while frozen must wait and then land
        fork
            apb(1'b1, ADDR_PC, 32'h0000_0155);
            begin
                repeat (4) @(posedge sys_clk);
                check({31'h0, pready}, 32'h0);
                check({21'h0, pc}, {21'h0, pcHeld});
                ce <= 1'b1;
            end
        join
        ce <= 1'b0;
        // a read whose setup is frozen must still return fresh data
        fork
            apb(1'b0, ADDR_PC, 32'h0);
            begin
                repeat (4) @(posedge sys_clk);
                check({31'h0, pready}, 32'h0);
                ce <= 1'b1;
            end
        join
        check(rdData, 32'h0000_0155);
    endtask : t_ce_low

    task automatic t_mid_reset();
        @(posedge sys_clk);
        rst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        check({21'h0, pc}, 32'h0);
        check({31'h0, wdtSlowClkSel}, 32'h0);
        apb(1'b0, ADDR_STATE, 32'h0);
        check(rdData, 32'h0);
    endtask : t_mid_reset

    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end

    // whole run needs a few hundred cycles; stop a hung handshake well after that
    initial begin
        repeat (5000) @(posedge sys_clk);
        errTotal++;
        results();
    end

    initial begin
        errTotal = 0;
        nChecks = 0;
        rst = 1'b1;
        ce = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        repeat (8) @(posedge sys_clk);
        rst <= 1'b0;
        t_reset();
        t_force_carry();
        t_param();
        t_shift_left();
        t_shift_right();
        t_skip();
        t_ce_low();
        t_mid_reset();
        results();
    end
endmodule : testbench

/* File: wdt_clock_model.sv */
// watchdog clock-select model driven by the executor's parameter nibble
`timescale 1ns/1ps
module wdt_clock_model
    import flag_shift_pkg::*;
#(
    parameter logic [15:0] FAST_DIVISOR = 16'h0004
)(
    input  wire logic        wdtSlowClkSel,
    output logic      [15:0] wdtDivisor
);
    // the watchdog sees only the select line, so reserved nibble bits cannot reach it
    always_comb begin
        wdtDivisor = wdtSlowClkSel ? 16'(WDT_SLOW_DIVISOR) : FAST_DIVISOR;
    end
endmodule : wdt_clock_model
